// ### hdl/pif_bank.v
// Peripheral interrupt enable and flag bank with AHB-Lite register access
`timescale 1ns/100ps
`include "pif_defines.vh"

module pif_bank (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire        parport_access,
	input  wire        conv_start,
	input  wire        conv_done,
	input  wire        conv_busy,
	input  wire        rx_buf_full,
	input  wire        tx_buf_empty,
	input  wire [1:0]  sync_mode,
	input  wire        sync_xfer_done,
	input  wire        sync_seq_done,
	input  wire        sync_bus_start,
	input  wire        sync_bus_stop,
	input  wire        sync_idle,
	input  wire [1:0]  capcomp_mode,
	input  wire        capcomp_capture,
	input  wire        capcomp_match,
	input  wire        timer_two_match,
	input  wire        timer_one_ovf,
	output wire        periph_irq,
	output wire [7:0]  pending_irqs
);

	// Bus data phase tracking
	reg        dp_active_reg;
	reg        dp_write_reg;
	reg [7:0]  dp_addr_reg;
	reg        rd_wait_reg;
	reg [31:0] hrdata_reg;
	reg        irq_reg;
	reg [7:0]  pending_reg;

	// Software-visible state
	reg [7:0]  enables_reg;
	reg [1:0]  control_reg;
	reg        rx_level_reg;
	reg        tx_level_reg;

	wire [7:0] flag_bits;
	wire [7:0] flags_read;
	wire [7:0] set_vec;
	wire [7:0] clr_vec;
	wire [7:0] status_byte;
	wire [7:0] control_byte;
	wire       global_irq_enable;
	wire       peripheral_gate_enable;
	wire       addr_phase;
	wire       wr_flags;
	wire       wr_enables;
	wire       wr_control;
	wire       sync_set;
	wire       sync_data_mode;
	wire       capcomp_set;
	wire       any_pending;
	wire       irq_next;
	wire [7:0] pending_next;

	assign global_irq_enable  = control_reg[1];
	assign peripheral_gate_enable = control_reg[0];

	// Address phase: only NONSEQ or SEQ with the bus ready
	assign addr_phase = hsel & hready &
		((htrans == `PIF_HTRANS_NONSEQ) | (htrans == `PIF_HTRANS_SEQ));

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_active_reg <= 1'b0;
			dp_write_reg  <= 1'b0;
			dp_addr_reg   <= 8'h00;
		end else if (hready) begin
			dp_active_reg <= addr_phase;
			dp_write_reg  <= hwrite;
			dp_addr_reg   <= haddr[7:0];
		end
	end

	// Reads take one wait state so data comes from settled flops
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rd_wait_reg <= 1'b0;
		else if (dp_active_reg & ~dp_write_reg & ~rd_wait_reg)
			rd_wait_reg <= 1'b1;
		else
			rd_wait_reg <= 1'b0;
	end

	assign hreadyout = ~(dp_active_reg & ~dp_write_reg & ~rd_wait_reg);
	assign hresp     = 1'b0;

	assign wr_flags   = dp_active_reg & dp_write_reg &
		(dp_addr_reg == `PIF_OFS_FLAGS);
	assign wr_enables = dp_active_reg & dp_write_reg &
		(dp_addr_reg == `PIF_OFS_ENABLES);
	assign wr_control = dp_active_reg & dp_write_reg &
		(dp_addr_reg == `PIF_OFS_CONTROL);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			enables_reg <= `PIF_ENABLES_RESET;
		else if (wr_enables)
			enables_reg <= hwdata[7:0];
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			control_reg <= `PIF_CONTROL_RESET;
		else if (wr_control) begin
			control_reg[1] <= hwdata[`PIF_CTL_GIE];
			control_reg[0] <= hwdata[`PIF_CTL_PERIPHERAL_GATE_ENABLE];
		end
	end

	// Buffer levels are sampled, never latched by software
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_level_reg <= 1'b0;
			tx_level_reg <= 1'b0;
		end else begin
			rx_level_reg <= rx_buf_full;
			tx_level_reg <= tx_buf_empty;
		end
	end

	// Sync serial sources differ by mode
	assign sync_data_mode = (sync_mode == `PIF_SYNC_SPI_MST) |
		(sync_mode == `PIF_SYNC_I2C_SLV) |
		(sync_mode == `PIF_SYNC_I2C_MST);
	assign sync_set =
		(sync_data_mode & sync_xfer_done) |
		((sync_mode == `PIF_SYNC_I2C_MST) & sync_seq_done) |
		((sync_mode == `PIF_SYNC_I2C_MST) & sync_idle &
		 (sync_bus_start | sync_bus_stop));

	// PWM mode leaves the capcomp flag untouched
	assign capcomp_set =
		((capcomp_mode == `PIF_CC_CAPTURE) & capcomp_capture) |
		((capcomp_mode == `PIF_CC_COMPARE) & capcomp_match);

	// Set events fire whatever the enables say
	assign set_vec[`PIF_BIT_PARPORT] = parport_access;
	assign set_vec[`PIF_BIT_CONV]    = conv_done;
	assign set_vec[`PIF_BIT_RX]      = 1'b0;
	assign set_vec[`PIF_BIT_TX]      = 1'b0;
	assign set_vec[`PIF_BIT_SYNC]    = sync_set;
	assign set_vec[`PIF_BIT_CAPCOMP] = capcomp_set;
	assign set_vec[`PIF_BIT_TIMER_TWO]    = timer_two_match;
	assign set_vec[`PIF_BIT_TIMER_ONE]    = timer_one_ovf;

	// A fresh conversion drops any stale completion
	assign clr_vec[`PIF_BIT_PARPORT] = 1'b0;
	assign clr_vec[`PIF_BIT_CONV]    = conv_start;
	assign clr_vec[`PIF_BIT_RX]      = 1'b0;
	assign clr_vec[`PIF_BIT_TX]      = 1'b0;
	assign clr_vec[`PIF_BIT_SYNC]    = 1'b0;
	assign clr_vec[`PIF_BIT_CAPCOMP] = 1'b0;
	assign clr_vec[`PIF_BIT_TIMER_TWO]    = 1'b0;
	assign clr_vec[`PIF_BIT_TIMER_ONE]    = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
			if (gi == `PIF_BIT_RX) begin : g_rx
				assign flag_bits[gi] = rx_level_reg;
			end else if (gi == `PIF_BIT_TX) begin : g_tx
				assign flag_bits[gi] = tx_level_reg;
			end else begin : g_sticky
				pif_flag_cell u_cell (
					.hclk    (hclk),
					.hresetn (hresetn),
					.set_evt (set_vec[gi]),
					.clr_evt (clr_vec[gi]),
					.wr_en   (wr_flags),
					.wr_val  (hwdata[gi]),
					.flag    (flag_bits[gi])
				);
			end
		end
	endgenerate

	// Incomplete conversion always reads as zero
	assign flags_read = {flag_bits[7],
		flag_bits[6] & ~conv_busy,
		flag_bits[5:0]};

	assign pending_next = flags_read & enables_reg;
	assign any_pending  = |pending_next;
	assign irq_next     = any_pending & peripheral_gate_enable & global_irq_enable;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_reg     <= 1'b0;
			pending_reg <= 8'h00;
		end else begin
			irq_reg     <= irq_next;
			pending_reg <= pending_next;
		end
	end

	assign control_byte = {global_irq_enable, peripheral_gate_enable, 6'h00};
	assign status_byte  = {6'h00, any_pending, irq_reg};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_reg <= 32'h00000000;
		else if (dp_active_reg & ~dp_write_reg & ~rd_wait_reg) begin
			case (dp_addr_reg)
			`PIF_OFS_FLAGS:   hrdata_reg <= {24'h000000, flags_read};
			`PIF_OFS_ENABLES: hrdata_reg <= {24'h000000, enables_reg};
			`PIF_OFS_CONTROL: hrdata_reg <= {24'h000000, control_byte};
			`PIF_OFS_STATUS:  hrdata_reg <= {24'h000000, status_byte};
			default:          hrdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign hrdata       = hrdata_reg;
	assign periph_irq   = irq_reg;
	assign pending_irqs = pending_reg;

endmodule

// ### hdl/pif_defines.vh
// Offsets, field positions, reset values and codes for the flag bank
`ifndef PIF_DEFINES_VH
`define PIF_DEFINES_VH

`define PIF_OFS_FLAGS      8'h0c
`define PIF_OFS_ENABLES    8'h8c
`define PIF_OFS_CONTROL    8'h90
`define PIF_OFS_STATUS     8'h94

`define PIF_FLAGS_RESET    8'h00
`define PIF_ENABLES_RESET  8'h00
`define PIF_CONTROL_RESET  2'h0

`define PIF_BIT_PARPORT    3'h7
`define PIF_BIT_CONV       3'h6
`define PIF_BIT_RX         3'h5
`define PIF_BIT_TX         3'h4
`define PIF_BIT_SYNC       3'h3
`define PIF_BIT_CAPCOMP    3'h2
`define PIF_BIT_TIMER_TWO       3'h1
`define PIF_BIT_TIMER_ONE       3'h0

`define PIF_CTL_GIE        7
`define PIF_CTL_PERIPHERAL_GATE_ENABLE       6

`define PIF_STS_REQ        0
`define PIF_STS_PENDING    1

`define PIF_SYNC_SPI_MST   2'h0
`define PIF_SYNC_I2C_SLV   2'h1
`define PIF_SYNC_I2C_MST   2'h2
`define PIF_SYNC_OFF       2'h3

`define PIF_CC_OFF         2'h0
`define PIF_CC_CAPTURE     2'h1
`define PIF_CC_COMPARE     2'h2
`define PIF_CC_PWM         2'h3

`define PIF_HTRANS_NONSEQ  2'h2
`define PIF_HTRANS_SEQ     2'h3

`endif

// ### hdl/pif_flag_cell.v
// One sticky interrupt flag with software write and hardware set
`timescale 1ns/100ps

module pif_flag_cell (
	input  wire hclk,
	input  wire hresetn,
	input  wire set_evt,
	input  wire clr_evt,
	input  wire wr_en,
	input  wire wr_val,
	output wire flag
);

	reg flag_reg;
	reg flag_next;

	always @* begin
		flag_next = flag_reg;
		if (clr_evt)
			flag_next = 1'b0;
		if (wr_en)
			flag_next = wr_val;
		// Hardware set beats any clear in the same cycle
		if (set_evt)
			flag_next = 1'b1;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	assign flag = flag_reg;

endmodule

// ### test/pif_bank_chk.sv
// Port-level assertions for the flag bank
`timescale 1ns/100ps
module pif_bank_chk (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        timer_one_ovf,
	input wire        periph_irq,
	input wire [7:0]  pending_irqs
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rd_go = hsel && hready && htrans[1] && !hwrite;
	wire wr_go = hsel && hready && htrans[1] && hwrite;
	chk_resp_okay:
		assert property (!hresp) else $error("bad hresp");
	chk_read_wait:
		assert property (rd_go |=> !hreadyout ##1 hreadyout)
		else $error("read wait");
	chk_write_nowait:
		assert property (wr_go |=> hreadyout) else $error("write wait");
	chk_wait_once:
		assert property (!hreadyout |=> hreadyout) else $error("long wait");
	chk_upper_zero:
		assert property (hrdata[31:8] == 24'h0) else $error("upper bits");
	chk_irq_needs_pend:
		assert property (periph_irq |-> pending_irqs != 8'h00)
		else $error("irq without source");
	chk_flag_sticky:
		assert property ($fell(pending_irqs[0]) |->
			$past(hwrite) || $past(hwrite, 2)) else $error("flag lost");
	chk_flag_cause:
		assert property ($rose(pending_irqs[0]) |-> $past(timer_one_ovf, 2)
			|| $past(hwrite) || $past(hwrite, 2)) else $error("flag cause");
endmodule
bind pif_bank pif_bank_chk chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hrdata, .hreadyout, .hresp, .timer_one_ovf, .periph_irq,
	.pending_irqs);

// ### test/pif_periph.sv
// Peripheral units raising one-cycle interrupt conditions
`timescale 1ns/100ps
module pif_periph (
	input  wire       hclk,
	input  wire [9:0] cmd,
	output reg  [9:0] ev = 10'h000
);
	// Registered so each event lands clear of the bench's own edge
	always @(posedge hclk) begin
		ev <= cmd;
	end
endmodule

// ### test/tb_peripheral_irq_enable_flag_bank.sv
// Self-checking bench for the peripheral flag bank
`timescale 1ns/100ps
`include "pif_defines.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
	error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_peripheral_irq_enable_flag_bank;
	reg        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	reg        conv_busy = 0, rx_f = 0, tx_e = 0, idle = 0, conv_st = 0;
	reg [31:0] haddr = 0, hwdata = 0;
	reg [1:0]  htrans = 0, sync_mode = 0, capcomp_mode = 0;
	reg [9:0]  cmd = 0;
	reg [7:0]  rd;
	wire [9:0] ev;
	wire [31:0] hrdata;
	wire       hready, hresp, periph_irq;
	wire [7:0] pending_irqs;
	integer    error_cnt = 0, check_count = 0, cyc = 0;
	initial forever #10 hclk = ~hclk;
	pif_periph peri (.hclk(hclk), .cmd(cmd), .ev(ev));
	pif_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .parport_access(ev[7]),
		.conv_start(conv_st), .conv_done(ev[6]), .conv_busy(conv_busy),
		.rx_buf_full(rx_f), .tx_buf_empty(tx_e), .sync_mode(sync_mode),
		.sync_xfer_done(ev[3]), .sync_seq_done(ev[5]),
		.sync_bus_start(ev[4]), .sync_bus_stop(ev[9]), .sync_idle(idle),
		.capcomp_mode(capcomp_mode), .capcomp_capture(ev[2]),
		.capcomp_match(ev[8]), .timer_two_match(ev[1]),
		.timer_one_ovf(ev[0]), .periph_irq(periph_irq),
		.pending_irqs(pending_irqs));
	task wt;
		do @(negedge hclk); while (hready !== 1'b1);
		rd = hrdata[7:0];
		@(posedge hclk);
	endtask
	task bus(input w, input [7:0] a, input [7:0] d);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= `PIF_HTRANS_NONSEQ;
		wt;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wt;
	endtask
	task rdc(input [7:0] a, input [7:0] e);
		bus(0, a, 8'h00);
		`CHK("reg", e, rd)
	endtask
	task evt(input [9:0] c, input [7:0] e);
		bus(1, `PIF_OFS_FLAGS, 8'h00);
		cmd <= c;
		@(posedge hclk);
		cmd <= 0;
		repeat (3) @(posedge hclk);
		rdc(`PIF_OFS_FLAGS, e);
	endtask
	task ctl(input [7:0] v, input e);
		bus(1, `PIF_OFS_CONTROL, v);
		repeat (3) @(negedge hclk);
		`CHK("irq", e, periph_irq)
		@(posedge hclk);
	endtask
	task t_regs;
		rdc(`PIF_OFS_FLAGS, `PIF_FLAGS_RESET);
		rdc(`PIF_OFS_ENABLES, `PIF_ENABLES_RESET);
		bus(1, `PIF_OFS_ENABLES, 8'ha5);
		bus(1, 8'h40, 8'hff);
		rdc(`PIF_OFS_ENABLES, 8'ha5);
		rdc(8'h40, 8'h00);
		bus(1, `PIF_OFS_ENABLES, 8'h00);
		bus(1, `PIF_OFS_FLAGS, 8'hff);
		rdc(`PIF_OFS_FLAGS, 8'hcf);
		rx_f <= 1;
		tx_e <= 1;
		repeat (2) @(posedge hclk);
		rdc(`PIF_OFS_FLAGS, 8'hff);
		rx_f <= 0;
		tx_e <= 0;
		$display("registers test done");
	endtask
	task t_events;
		evt(10'h083, 8'h83);
		evt(10'h040, 8'h40);
		conv_busy <= 1;
		repeat (2) @(posedge hclk);
		rdc(`PIF_OFS_FLAGS, 8'h00);
		conv_busy <= 0;
		// Stored completion survives the busy mask
		rdc(`PIF_OFS_FLAGS, 8'h40);
		conv_st <= 1;
		@(posedge hclk);
		conv_st <= 0;
		repeat (2) @(posedge hclk);
		rdc(`PIF_OFS_FLAGS, 8'h00);
		capcomp_mode <= `PIF_CC_PWM;
		evt(10'h104, 8'h00);
		capcomp_mode <= `PIF_CC_CAPTURE;
		evt(10'h004, 8'h04);
		capcomp_mode <= `PIF_CC_COMPARE;
		evt(10'h100, 8'h04);
		for (int m = 0; m < 4; m++) begin
			sync_mode <= m[1:0];
			evt(10'h008, (m < 3) ? 8'h08 : 8'h00);
		end
		evt(10'h020, 8'h00);
		sync_mode <= `PIF_SYNC_I2C_MST;
		evt(10'h020, 8'h08);
		evt(10'h210, 8'h00);
		idle <= 1;
		evt(10'h010, 8'h08);
		evt(10'h200, 8'h08);
		$display("events test done");
	endtask
	task t_irq;
		bus(1, `PIF_OFS_FLAGS, 8'h00);
		bus(1, `PIF_OFS_ENABLES, 8'h01);
		evt(10'h001, 8'h01);
		`CHK("pend", 8'h01, pending_irqs)
		ctl(8'h00, 1'b0);
		ctl(8'h40, 1'b0);
		ctl(8'h80, 1'b0);
		ctl(8'hc0, 1'b1);
		rdc(`PIF_OFS_STATUS, 8'h03);
		rdc(`PIF_OFS_CONTROL, 8'hc0);
		bus(1, `PIF_OFS_FLAGS, 8'h00);
		ctl(8'hc0, 1'b0);
		ctl(8'h00, 1'b0);
		$display("interrupt test done");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run;
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		t_regs;
		t_events;
		t_irq;
		complete_run;
	end
endmodule
